/* File: rtl/lateral_tilt_pkg.sv */
package lateral_tilt_pkg;

	// Object indices of the lateral objects.
	localparam logic [15:0] IDX_OP_PARAM     = 16'h6021;
	localparam logic [15:0] IDX_PRESET       = 16'h6022;
	localparam logic [15:0] IDX_AUTO_OFFSET  = 16'h6023;
	localparam logic [15:0] IDX_DIFF_OFFSET  = 16'h6024;
	localparam logic [15:0] IDX_TILT_VALUE   = 16'h6020;
	localparam logic [15:0] IDX_WIDE_BASE    = 16'h6120;
	localparam logic [15:0] IDX_WIDE_LAST    = 16'h6124;
	localparam logic [15:0] IDX_WIDE_DELTA   = 16'h0100;
	localparam logic [15:0] IDX_PRESET_Y     = 16'h2601;

	// Operating parameter field positions and reset values.
	localparam int          OP_INVERT_BIT    = 0;
	localparam int          OP_SCALE_BIT     = 1;
	localparam logic [7:0]  OP_RESET         = 8'h02;
	localparam logic [15:0] PRESET_RESET     = 16'h0000;
	localparam logic [15:0] OFFSET_RESET     = 16'h0000;

	// Saturation limits of the signed 16-bit output.
	localparam logic signed [17:0] SAT_MAX   = 18'sh07FFF;
	localparam logic signed [17:0] SAT_MIN   = -18'sh08000;

	// One object access from the master.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] index;
		logic [31:0] data;
	} obj_req_t;

	// Answer to one access.
	typedef struct packed {
		logic        valid;
		logic        error;
		logic [31:0] data;
	} obj_rsp_t;

endpackage

/* File: rtl/lateral_calc.sv */
`timescale 1ns/1ps
// Combinational output and offset arithmetic for the lateral axis.
module lateral_calc (
	input  wire logic signed [15:0] phys_in,
	input  wire logic               invert_in,
	input  wire logic               scale_in,
	input  wire logic signed [15:0] auto_off_in,
	input  wire logic signed [15:0] diff_off_in,
	input  wire logic signed [15:0] preset_in,
	output logic signed [15:0]      tilt_out,
	output logic signed [15:0]      offset_out
);
	logic signed [17:0] signed_phys;
	logic signed [17:0] sum;
	logic signed [17:0] off;

	// Signed physical value with multiplier, then optional offsets.
	always_comb begin
		signed_phys = invert_in ? -18'(phys_in) : 18'(phys_in);
		sum = scale_in ? signed_phys + 18'(auto_off_in) + 18'(diff_off_in)
			: signed_phys;
		if (sum > lateral_tilt_pkg::SAT_MAX) begin
			tilt_out = 16'(lateral_tilt_pkg::SAT_MAX);
		end else if (sum < lateral_tilt_pkg::SAT_MIN) begin
			tilt_out = 16'(lateral_tilt_pkg::SAT_MIN);
		end else begin
			tilt_out = sum[15:0];
		end
		// Offset wraps to 16 bits; valid presets keep it in range.
		off = 18'(preset_in) - signed_phys - 18'(diff_off_in);
		offset_out = off[15:0];
	end
endmodule

/* File: rtl/lateral_tilt_preset_offset.sv */
`timescale 1ns/1ps
// Contract
// - Bit 0 inverts, bit 1 adds offsets.
// - Operating byte resets to value 2.
// - Single-axis sensor reports lateral value zero.
// - Multiplier is +1, or -1 when inverted.
// - Scaled output adds auto and differential offsets.
// - Signed preset, default zero, sets current output.
// - Preset is in current resolution units.
// - Offset recomputed on any preset object write.
// - Offset = preset - signed physical - differential.
// - Automatic offset is signed and read only.
// - Differential offset counts only when scaling.
// - Full-circle single-axis variant lacks auto offset.
// - Wide lateral objects alias the 16-bit ones.
// - Preset correct only inside limited range.
module lateral_tilt_preset_offset #(
	parameter bit DUAL_AXIS   = 1'b1,
	parameter bit HAS_AUTO_OFF = 1'b1
) (
	// Clock and reset.
	input  wire logic                       MCLK_IN,
	input  wire logic                       RST_IN,
	// Physical lateral inclination, in current resolution units.
	input  wire logic signed [15:0]         PHYS_IN,
	// Object access from the master.
	input  wire lateral_tilt_pkg::obj_req_t REQ_IN,
	output lateral_tilt_pkg::obj_rsp_t      RSP_OUT,
	// Computed lateral output.
	output logic signed [15:0]              TILT_OUT
);
	logic [7:0]         op_r,      op_nxt;
	logic signed [15:0] preset_r,  preset_nxt;
	logic signed [15:0] auto_r,    auto_nxt;
	logic signed [15:0] diff_r,    diff_nxt;
	logic signed [15:0] tilt_r,    tilt_nxt;
	lateral_tilt_pkg::obj_rsp_t rsp_r, rsp_nxt;
	logic [15:0]        idx;
	logic signed [15:0] calc_tilt;
	logic signed [15:0] calc_off;
	logic signed [15:0] wdata;
	logic               preset_wr;

	// All checks below run on the one clock and rest while in reset.
	default clocking cb_main @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);

	// Wide view folds onto the 16-bit indices; upper bits are dropped.
	always_comb begin
		idx = REQ_IN.index;
		if (REQ_IN.index >= lateral_tilt_pkg::IDX_WIDE_BASE &&
			REQ_IN.index <= lateral_tilt_pkg::IDX_WIDE_LAST) begin
			idx = REQ_IN.index - lateral_tilt_pkg::IDX_WIDE_DELTA;
		end
		wdata = REQ_IN.data[15:0];
	end

	// Preset written via 16-bit, wide or Y-axis preset object.
	assign preset_wr = REQ_IN.wr &&
		(idx == lateral_tilt_pkg::IDX_PRESET ||
		 idx == lateral_tilt_pkg::IDX_PRESET_Y);

	// The offset is taken from the new preset and the live physical value.
	lateral_calc calc (
		.phys_in     (PHYS_IN),
		.invert_in   (op_r[lateral_tilt_pkg::OP_INVERT_BIT]),
		.scale_in    (op_r[lateral_tilt_pkg::OP_SCALE_BIT]),
		.auto_off_in (auto_r),
		.diff_off_in (diff_r),
		.preset_in   (preset_wr ? wdata : preset_r),
		.tilt_out    (calc_tilt),
		.offset_out  (calc_off)
	);

	// Register writes, reads and output update.
	always_comb begin
		op_nxt     = op_r;
		preset_nxt = preset_r;
		auto_nxt   = auto_r;
		diff_nxt   = diff_r;
		rsp_nxt    = '0;
		tilt_nxt   = DUAL_AXIS ? calc_tilt : 16'sh0000;
		if (REQ_IN.wr) begin
			rsp_nxt.valid = 1'b1;
			unique case (idx)
				lateral_tilt_pkg::IDX_OP_PARAM:
					op_nxt = REQ_IN.data[7:0];
				lateral_tilt_pkg::IDX_PRESET,
				lateral_tilt_pkg::IDX_PRESET_Y:
					preset_nxt = wdata;
				lateral_tilt_pkg::IDX_DIFF_OFFSET:
					diff_nxt = wdata;
				default:
					rsp_nxt.error = 1'b1;
			endcase
			if (preset_wr && HAS_AUTO_OFF) begin
				auto_nxt = calc_off;
			end
		end else if (REQ_IN.rd) begin
			rsp_nxt.valid = 1'b1;
			unique case (idx)
				lateral_tilt_pkg::IDX_TILT_VALUE:
					rsp_nxt.data = 32'(tilt_r);
				lateral_tilt_pkg::IDX_OP_PARAM:
					rsp_nxt.data = {24'h000000, op_r};
				lateral_tilt_pkg::IDX_PRESET,
				lateral_tilt_pkg::IDX_PRESET_Y:
					rsp_nxt.data = 32'(preset_r);
				lateral_tilt_pkg::IDX_AUTO_OFFSET: begin
					if (HAS_AUTO_OFF) begin
						rsp_nxt.data = 32'(auto_r);
					end else begin
						rsp_nxt.error = 1'b1;
					end
				end
				lateral_tilt_pkg::IDX_DIFF_OFFSET:
					rsp_nxt.data = 32'(diff_r);
				default:
					rsp_nxt.error = 1'b1;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			op_r     <= lateral_tilt_pkg::OP_RESET;
			preset_r <= lateral_tilt_pkg::PRESET_RESET;
			auto_r   <= lateral_tilt_pkg::OFFSET_RESET;
			diff_r   <= lateral_tilt_pkg::OFFSET_RESET;
			tilt_r   <= 16'sh0000;
			rsp_r    <= '0;
		end else begin
			op_r     <= op_nxt;
			preset_r <= preset_nxt;
			auto_r   <= auto_nxt;
			diff_r   <= diff_nxt;
			tilt_r   <= tilt_nxt;
			rsp_r    <= rsp_nxt;
		end
	end

	assign RSP_OUT  = rsp_r;
	assign TILT_OUT = tilt_r;

	// Checks next to the logic. Range guards keep the wrapped offset from
	// aliasing, so the arithmetic checks stay exact.
	sequence s_preset_write;
		REQ_IN.wr && (idx == lateral_tilt_pkg::IDX_PRESET);
	endsequence

	// Quiet cycle after a preset, with every term well inside 16 bits.
	sequence s_preset_settles;
		op_r[1] && !REQ_IN.wr && $stable(PHYS_IN) &&
		HAS_AUTO_OFF && DUAL_AXIS && $past(wdata) > -16'sd9000 &&
		$past(wdata) < 16'sd9000 && diff_r > -16'sd9000 &&
		diff_r < 16'sd9000 && PHYS_IN > -16'sd9000 &&
		PHYS_IN < 16'sd9000;
	endsequence

	// Defaults seen at the first edge after any reset release.
	a_reset_op_value: assert property (
		$fell(RST_IN) |-> op_r == lateral_tilt_pkg::OP_RESET)
		else $error("operating byte not 2 after reset");
	a_reset_preset: assert property (
		$fell(RST_IN) |-> preset_r == lateral_tilt_pkg::PRESET_RESET)
		else $error("preset not zero after reset");

	// Operating byte write and the output forms that it selects.
	a_op_write: assert property (
		REQ_IN.wr && idx == lateral_tilt_pkg::IDX_OP_PARAM |=>
		op_r == $past(REQ_IN.data[7:0]))
		else $error("operating byte not written");
	a_invert_only: assert property (
		DUAL_AXIS && op_r == 8'h01 && $stable(op_r) |=>
		tilt_r == -$past(PHYS_IN) || $past(PHYS_IN) == -16'sh8000)
		else $error("inverted output wrong");
	a_plain_output: assert property (
		DUAL_AXIS && op_r == 8'h00 |=> tilt_r == $past(PHYS_IN))
		else $error("unscaled output not physical value");
	a_scaled_sum: assert property (
		DUAL_AXIS && op_r == 8'h02 && PHYS_IN > -16'sd9000 &&
		PHYS_IN < 16'sd9000 && auto_r > -16'sd9000 &&
		auto_r < 16'sd9000 && diff_r > -16'sd9000 &&
		diff_r < 16'sd9000 |=>
		tilt_r == 16'($past(PHYS_IN) + $past(auto_r) + $past(diff_r)))
		else $error("scaled output not sum of terms");
	a_preset_hits: assert property (
		s_preset_write ##1 s_preset_settles |=> tilt_r == $past(preset_r))
		else $error("preset not reached");
	a_saturate: assert property (
		DUAL_AXIS && op_r == 8'h02 && $stable(op_r) &&
		$stable(auto_r) && $stable(diff_r) && auto_r == 16'sh7FFF &&
		diff_r == 16'sh7FFF && PHYS_IN >= 16'sh0000 |=>
		tilt_r == 16'sh7FFF)
		else $error("scaled sum not saturated");

	// Automatic offset: recomputed only by a preset, never written.
	a_offset_update: assert property (
		preset_wr && HAS_AUTO_OFF |=>
		auto_r == 16'($past(wdata) - $past(diff_r) -
		($past(op_r[0]) ? -$past(PHYS_IN) : $past(PHYS_IN))))
		else $error("offset not recomputed");
	a_offset_hold: assert property (
		!preset_wr |=> $stable(auto_r))
		else $error("offset changed without preset");
	a_auto_read_only: assert property (
		REQ_IN.wr && idx == lateral_tilt_pkg::IDX_AUTO_OFFSET |=>
		RSP_OUT.error && $stable(auto_r))
		else $error("automatic offset write not refused");
	a_auto_absent: assert property (
		!HAS_AUTO_OFF && REQ_IN.rd && !REQ_IN.wr &&
		idx == lateral_tilt_pkg::IDX_AUTO_OFFSET |=> RSP_OUT.error)
		else $error("missing offset object answered");
	a_auto_frozen: assert property (
		!HAS_AUTO_OFF |-> auto_r == lateral_tilt_pkg::OFFSET_RESET)
		else $error("missing offset object changed");

	// Single-axis variant, the wide view and the answer pulse.
	a_single_axis: assert property (
		!DUAL_AXIS |-> tilt_r == 16'sh0000)
		else $error("single axis value not zero");
	a_wide_alias: assert property (
		REQ_IN.wr && REQ_IN.index == lateral_tilt_pkg::IDX_WIDE_LAST |=>
		diff_r == $past(REQ_IN.data[15:0]))
		else $error("wide view not aliased");
	a_wide_preset: assert property (
		REQ_IN.wr && REQ_IN.index ==
		lateral_tilt_pkg::IDX_PRESET + lateral_tilt_pkg::IDX_WIDE_DELTA |=>
		preset_r == $past(REQ_IN.data[15:0]))
		else $error("wide preset not aliased");
	a_answer_pulse: assert property (
		REQ_IN.wr || REQ_IN.rd |=> RSP_OUT.valid)
		else $error("access not answered");
endmodule

/* File: sim/lateral_master_model.sv */
`timescale 1ns/1ps
// Object master: one access per call, held for exactly one clock.
module lateral_master_model (
	input  wire logic                 clk_in,
	output lateral_tilt_pkg::obj_req_t req_out
);
	initial req_out = '0;
	// Drives just after an edge so the device samples a settled request.
	task automatic access(input logic w, input logic [15:0] idx,
		input logic [31:0] d);
		@(posedge clk_in);
		#1 req_out = {w, ~w, idx, d};
		@(posedge clk_in);
		#1 req_out = '0;
	endtask
endmodule

/* File: sim/lateral_tilt_preset_offset_tb_top.sv */
`timescale 1ns/1ps
// Drives the lateral block through the master model and checks answers.
module lateral_tilt_preset_offset_tb_top;
	logic                       mclk = 1'b0;
	logic                       rst = 1'b1;
	logic signed [15:0]         phys = 16'sh0000;
	lateral_tilt_pkg::obj_req_t req;
	lateral_tilt_pkg::obj_rsp_t rsp;
	logic signed [15:0]         tilt;
	lateral_tilt_pkg::obj_rsp_t rsp_s;
	logic signed [15:0]         tilt_s;
	logic [34:0]                exp_q[$];
	logic [34:0]                e;
	logic [7:0]                 op;
	logic signed [15:0]         pre, diff, aoff;
	logic [15:0]                pidx[3];
	int                         num_errors = 0;
	int                         comparisons = 0;

	always #5 mclk = ~mclk;

	lateral_master_model i_master (.clk_in(mclk), .req_out(req));
	lateral_tilt_preset_offset i_dut (.MCLK_IN(mclk), .RST_IN(rst),
		.PHYS_IN(phys), .REQ_IN(req), .RSP_OUT(rsp), .TILT_OUT(tilt));
	// Single-axis variant without the automatic offset sees the same traffic.
	lateral_tilt_preset_offset #(.DUAL_AXIS(1'b0), .HAS_AUTO_OFF(1'b0))
		i_dut_single (.MCLK_IN(mclk), .RST_IN(rst), .PHYS_IN(phys),
		.REQ_IN(req), .RSP_OUT(rsp_s), .TILT_OUT(tilt_s));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Writes carry no data check; the note goes in before the request.
	task automatic acc(input logic w, input logic [15:0] idx,
		input logic [31:0] d, input logic er);
		// The top bit is the refusal that the single-axis variant gives.
		exp_q.push_back({er | (~w & (idx == 16'h6023)), ~w, er, d});
		i_master.access(w, idx, w ? {16'h0000, d[15:0]} : 32'h00000000);
	endtask

	// Output as the device should form it, saturated to 16 bits.
	function automatic logic [31:0] tilt_exp();
		logic signed [17:0] s;
		s = op[0] ? -phys : phys;
		if (op[1])
			s = s + aoff + diff;
		if (s > 18'sh07FFF)
			s = 18'sh07FFF;
		if (s < -18'sh08000)
			s = -18'sh08000;
		return {{16{s[15]}}, s[15:0]};
	endfunction

	// Each answer is matched with the oldest note once it has settled.
	always @(posedge mclk) begin
		#2;
		if (rsp.valid === 1'b1) begin
			e = exp_q.pop_front();
			chk({31'h0, rsp.error}, {31'h0, e[32]});
			if (e[33])
				chk(rsp.data, e[31:0]);
			chk({30'h0, rsp_s.valid, rsp_s.error}, {31'h1, e[34]});
			chk(32'(tilt_s), 32'h00000000);
		end
	end

	task automatic close_out();
		chk(32'(exp_q.size()), 32'h00000000);
		$display("comparisons=%0d errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// A run of under 300 cycles; this limit only cuts a hang.
	initial begin
		#100us;
		num_errors++;
		close_out();
	end

	initial begin
		void'($urandom(40));
		pidx = '{16'h6022, 16'h6122, 16'h2601};
		op = 8'h02;
		pre = 16'sh0000;
		diff = 16'sh0000;
		aoff = 16'sh0000;
		repeat (6) @(posedge mclk);
		#1 rst = 1'b0;
		acc(1'b0, 16'h6021, 32'h00000002, 1'b0);
		acc(1'b0, 16'h6022, 32'h00000000, 1'b0);
		$display("test reset values done");
		for (int i = 0; i < 12; i++) begin
			op = 8'($urandom_range(3));
			phys = 16'($urandom_range(180) - 90);
			diff = 16'($urandom_range(40) - 20);
			pre = 16'($urandom_range(180) - 90);
			acc(1'b1, 16'h6021, {24'h0, op}, 1'b0);
			acc(1'b1, i[0] ? 16'h6124 : 16'h6024, diff, 1'b0);
			aoff = pre - (op[0] ? -phys : phys) - diff;
			acc(1'b1, pidx[i % 3], pre, 1'b0);
			repeat (3) @(posedge mclk);
			acc(1'b0, 16'h6023, {{16{aoff[15]}}, aoff}, 1'b0);
			acc(1'b0, 16'h6020, tilt_exp(), 1'b0);
			chk(32'(tilt), tilt_exp());
			phys = 16'($urandom());
			repeat (3) @(posedge mclk);
			acc(1'b0, 16'h6120, tilt_exp(), 1'b0);
		end
		$display("test preset and output done");
		// Offset and differential both at the top of the range overflow.
		op = 8'h02;
		phys = 16'sh0000;
		diff = 16'sh7FFF;
		pre = 16'shFFFE;
		acc(1'b1, 16'h6021, {24'h0, op}, 1'b0);
		acc(1'b1, 16'h6024, diff, 1'b0);
		aoff = pre - (op[0] ? -phys : phys) - diff;
		acc(1'b1, 16'h6022, pre, 1'b0);
		repeat (3) @(posedge mclk);
		acc(1'b0, 16'h6020, tilt_exp(), 1'b0);
		chk(32'(tilt), 32'h00007FFF);
		$display("test saturation done");
		acc(1'b1, 16'h6023, 32'h00001234, 1'b1);
		acc(1'b0, 16'h6023, {{16{aoff[15]}}, aoff}, 1'b0);
		acc(1'b1, 16'h6020, 32'h00001234, 1'b1);
		$display("test refusals done");
		// A second reset after the last answer has been taken.
		repeat (2) @(posedge mclk);
		#1 rst = 1'b1;
		op = 8'h02;
		diff = 16'sh0000;
		aoff = 16'sh0000;
		repeat (6) @(posedge mclk);
		#1 rst = 1'b0;
		acc(1'b0, 16'h6021, 32'h00000002, 1'b0);
		acc(1'b0, 16'h6122, 32'h00000000, 1'b0);
		acc(1'b0, 16'h6023, 32'h00000000, 1'b0);
		acc(1'b0, 16'h6024, 32'h00000000, 1'b0);
		acc(1'b0, 16'h6020, tilt_exp(), 1'b0);
		$display("test second reset done");
		repeat (4) @(posedge mclk);
		close_out();
	end
endmodule
